// File: rtl/xfd_pkg.sv
// Package: constants for the exclusive-OR decode and extended group slice
package xfd_pkg;
  // ****************************************
  // Opcode fields
  // ****************************************
  localparam logic [5:0] XFD_OP_XOR_FILE = 6'h06;
  localparam logic [7:0] XFD_OP_ADDPTR = 8'he8;
  localparam logic [7:0] XFD_OP_SUBPTR = 8'he9;
  localparam logic [7:0] XFD_OP_PUSHL = 8'hea;
  localparam logic [7:0] XFD_OP_MOVS = 8'heb;
  localparam logic [15:0] XFD_OP_CALLW = 16'h0014;
  localparam logic [7:0] XFD_IDX_LIMIT = 8'h5f;
  localparam logic [3:0] XFD_ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] XFD_ACCESS_HIGH_BANK = 4'hf;
  localparam logic [1:0] XFD_PTR_THIRD = 2'h3;
  // ****************************************
  // AXI4-Lite register map
  // ****************************************
  localparam logic [7:0] XFD_ADDR_CTRL = 8'h00;
  localparam logic [7:0] XFD_ADDR_BANK = 8'h04;
  localparam logic [7:0] XFD_ADDR_WREG = 8'h08;
  localparam logic [7:0] XFD_ADDR_PTR2 = 8'h0c;
  localparam logic [7:0] XFD_ADDR_STATUS = 8'h10;
  localparam logic [7:0] XFD_ADDR_CLASS = 8'h14;
  localparam logic [1:0] XFD_RESP_OKAY = 2'b00;
  localparam logic [1:0] XFD_RESP_SLVERR = 2'b10;
  // Extended instruction classes
  typedef enum logic [3:0] {
    XFD_CL_NONE, XFD_CL_XOR, XFD_CL_ADDPTR, XFD_CL_SUBPTR, XFD_CL_ADDRET,
    XFD_CL_SUBRET, XFD_CL_CALLW, XFD_CL_MOVSF, XFD_CL_MOVSS, XFD_CL_PUSHL
  } xfd_class_t;
endpackage : xfd_pkg

// File: rtl/xfd_axil.sv
// AXI4-Lite slave front end with a flat register port
`timescale 1ns/1ps
`default_nettype none
module xfd_axil (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import xfd_pkg::*;
  logic aw_ff, nxt_aw;
  logic w_ff, nxt_w;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0] ws_ff, nxt_ws;
  logic bv_ff, nxt_bv;
  logic [1:0] br_ff, nxt_br;
  logic rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0] rr_ff, nxt_rr;
  // Address and data are latched independently, either order
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    if (s_axi_awvalid && !aw_ff && !bv_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff && !bv_ff) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    if (aw_ff && w_ff) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = wr_ok ? XFD_RESP_OKAY : XFD_RESP_SLVERR;
    end
    if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
  end
  // Read answers one cycle after the address is taken
  always_comb begin
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_arvalid && !rv_ff) begin
      nxt_rv = 1'b1;
      nxt_rd = rd_data;
      nxt_rr = rd_ok ? XFD_RESP_OKAY : XFD_RESP_SLVERR;
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= 2'b00;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= 2'b00;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end
  assign s_axi_awready = s_axi_awvalid && !aw_ff && !bv_ff;
  assign s_axi_wready = s_axi_wvalid && !w_ff && !bv_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = s_axi_arvalid && !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
  assign wr_en = aw_ff && w_ff;
  assign wr_addr = awa_ff;
  assign wr_data = wd_ff;
  assign wr_strb = ws_ff;
  assign rd_addr = s_axi_araddr;
endmodule : xfd_axil
`default_nettype wire

// File: rtl/xfd_decode.sv
// Exclusive-OR with file register decode and extended group classification
// Behaviour
// - Opcode 000110 d a f: XOR working register with addressed file register.
// - Destination bit clear writes working register; set writes file register.
// - Bank bit clear resolves address inside access bank, ignoring bank pointer.
// - Bank bit set combines address with bank selection register.
// - Extension on, bank bit clear, address <= 95: offset from third pointer.
// - Extension group and indexed mode off at reset until config bit set; the code also needs the CTRL control bit set.
// - When enabled, eight additional instructions are accepted.
// - Extended instructions are literal pointer updates or pointer-indexed accesses.
// - Pointer add/subtract aimed at third pointer also return from subroutine.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module xfd_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch stream
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  // Configuration strap
  input wire logic extension_enable_config_bit,
  // Data memory
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Extended group outputs
  output logic ext_valid,
  output logic [3:0] ext_class,
  output logic illegal_op,
  output logic return_req,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import xfd_pkg::*;
  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [1:0] {XFD_Q1, XFD_Q2, XFD_Q3, XFD_Q4} xfd_phase_t;
  xfd_phase_t ph_ff, nxt_ph;
  logic [15:0] ir_ff, nxt_ir;
  logic is_xor_ff, nxt_is_xor;
  logic [7:0] res_ff, nxt_res;
  logic [7:0] wreg_ff, nxt_wreg;
  logic [3:0] bank_selection_register_ff, nxt_bank;
  logic [11:0] third_file_pointer_ff, nxt_ptr2;
  logic neg_ff, nxt_neg;
  logic zero_ff, nxt_zero;
  logic xen_ff, nxt_xen;
  logic [11:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd;
  logic wr_ff, nxt_wr;
  logic [7:0] wd_ff, nxt_wd;
  logic evalid_ff, nxt_evalid;
  logic [3:0] eclass_ff, nxt_eclass;
  logic ill_ff, nxt_ill;
  logic ret_ff, nxt_ret;
  logic cfg_meta_ff, nxt_cfg_meta;
  logic cfg_sync_ff, nxt_cfg_sync;
  logic ext_on;
  logic bus_wen, bus_wok, bus_rok;
  logic [7:0] bus_waddr, bus_raddr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [3:0] bus_wstrb;
  logic [11:0] eff_addr;
  xfd_class_t cls;

  // ****************************************
  // Bus slave
  // ****************************************
  xfd_axil u_axil (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(bus_wen), .wr_addr(bus_waddr), .wr_data(bus_wdata), .wr_strb(bus_wstrb),
    .wr_ok(bus_wok), .rd_addr(bus_raddr), .rd_data(bus_rdata), .rd_ok(bus_rok)
  );

  // Address decode for both directions
  always_comb begin
    bus_wok = (bus_waddr == XFD_ADDR_BANK) || (bus_waddr == XFD_ADDR_WREG) ||
              (bus_waddr == XFD_ADDR_PTR2) || (bus_waddr == XFD_ADDR_CTRL) ||
              (bus_waddr == XFD_ADDR_STATUS) || (bus_waddr == XFD_ADDR_CLASS);
    bus_rok = 1'b1;
    case (bus_raddr)
      XFD_ADDR_CTRL: bus_rdata = {31'h0000_0000, xen_ff};
      XFD_ADDR_BANK: bus_rdata = {28'h000_0000, bank_selection_register_ff};
      XFD_ADDR_WREG: bus_rdata = {24'h00_0000, wreg_ff};
      XFD_ADDR_PTR2: bus_rdata = {20'h0_0000, third_file_pointer_ff};
      XFD_ADDR_STATUS: bus_rdata = {30'h0000_0000, neg_ff, zero_ff};
      XFD_ADDR_CLASS: bus_rdata = {28'h000_0000, eclass_ff};
      default: begin
        bus_rdata = 32'h0000_0000;
        bus_rok = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Instruction classification
  // ****************************************
  // Extended opcodes decode only with the extension latched on
  always_comb begin
    cls = XFD_CL_NONE;
    if (instr_word[15:10] == XFD_OP_XOR_FILE) begin
      cls = XFD_CL_XOR;
    end else if (ext_on) begin
      case (instr_word[15:8])
        XFD_OP_ADDPTR: cls = (instr_word[7:6] == XFD_PTR_THIRD) ? XFD_CL_ADDRET
                                                                  : XFD_CL_ADDPTR;
        XFD_OP_SUBPTR: cls = (instr_word[7:6] == XFD_PTR_THIRD) ? XFD_CL_SUBRET
                                                                  : XFD_CL_SUBPTR;
        XFD_OP_PUSHL: cls = XFD_CL_PUSHL;
        XFD_OP_MOVS: cls = instr_word[7] ? XFD_CL_MOVSS : XFD_CL_MOVSF;
        default: cls = (instr_word == XFD_OP_CALLW) ? XFD_CL_CALLW : XFD_CL_NONE;
      endcase
    end
  end

  // Effective file address: access bank, banked, or indexed offset
  always_comb begin
    if (ir_ff[8]) begin
      eff_addr = {bank_selection_register_ff, ir_ff[7:0]};
    end else if (ext_on && (ir_ff[7:0] <= XFD_IDX_LIMIT)) begin
      eff_addr = third_file_pointer_ff + {4'h0, ir_ff[7:0]};
    end else if (ir_ff[7]) begin
      eff_addr = {XFD_ACCESS_HIGH_BANK, ir_ff[7:0]};
    end else begin
      eff_addr = {XFD_ACCESS_LOW_BANK, ir_ff[7:0]};
    end
  end

  // ****************************************
  // Phase sequencer and execution
  // ****************************************
  // Four phases per instruction cycle; a new word is only taken in Q1
  always_comb begin
    nxt_ph = ph_ff;
    nxt_ir = ir_ff;
    nxt_is_xor = is_xor_ff;
    nxt_res = res_ff;
    nxt_wreg = wreg_ff;
    nxt_bank = bank_selection_register_ff;
    nxt_ptr2 = third_file_pointer_ff;
    nxt_neg = neg_ff;
    nxt_zero = zero_ff;
    nxt_xen = xen_ff;
    nxt_addr = addr_ff;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    nxt_wd = wd_ff;
    nxt_evalid = 1'b0;
    nxt_eclass = eclass_ff;
    nxt_ill = 1'b0;
    nxt_ret = 1'b0;
    nxt_cfg_meta = extension_enable_config_bit;
    nxt_cfg_sync = cfg_meta_ff;
    case (ph_ff)
      XFD_Q1: begin
        // Phases run free; an idle Q1 must not leave a stale XOR pending
        nxt_ph = XFD_Q2;
        nxt_is_xor = instr_valid && (cls == XFD_CL_XOR);
        if (instr_valid) begin
          nxt_ir = instr_word;
          nxt_eclass = cls;
          nxt_evalid = (cls != XFD_CL_NONE) && (cls != XFD_CL_XOR);
          nxt_ret = (cls == XFD_CL_ADDRET) || (cls == XFD_CL_SUBRET);
          // Extended-looking words with extension off are flagged, not run
          nxt_ill = (cls == XFD_CL_NONE) && !ext_on && (instr_word[15:12] == 4'he);
        end
      end
      XFD_Q2: begin
        nxt_ph = XFD_Q3;
        nxt_addr = eff_addr;
        nxt_rd = is_xor_ff;
      end
      XFD_Q3: begin
        nxt_ph = XFD_Q4;
        nxt_res = wreg_ff ^ mem_rdata;
      end
      XFD_Q4: begin
        nxt_ph = XFD_Q1;
        if (is_xor_ff) begin
          nxt_neg = res_ff[7];
          nxt_zero = (res_ff == 8'h00);
          if (ir_ff[9]) begin
            nxt_wr = 1'b1;
            nxt_wd = res_ff;
          end else begin
            nxt_wreg = res_ff;
          end
        end
      end
      default: nxt_ph = XFD_Q1;
    endcase
    // Software writes apply in any phase and win over the Q4 update
    if (bus_wen && bus_wstrb[0]) begin
      case (bus_waddr)
        XFD_ADDR_CTRL: nxt_xen = bus_wdata[0];
        XFD_ADDR_BANK: nxt_bank = bus_wdata[3:0];
        XFD_ADDR_WREG: nxt_wreg = bus_wdata[7:0];
        XFD_ADDR_PTR2: nxt_ptr2[7:0] = bus_wdata[7:0];
        default: nxt_xen = xen_ff;
      endcase
    end
    if (bus_wen && bus_wstrb[1] && (bus_waddr == XFD_ADDR_PTR2)) begin
      nxt_ptr2[11:8] = bus_wdata[11:8];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_ff <= XFD_Q1;
      ir_ff <= 16'h0000;
      is_xor_ff <= 1'b0;
      res_ff <= 8'h00;
      wreg_ff <= 8'h00;
      bank_selection_register_ff <= 4'h0;
      third_file_pointer_ff <= 12'h000;
      neg_ff <= 1'b0;
      zero_ff <= 1'b0;
      xen_ff <= 1'b0;
      addr_ff <= 12'h000;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      wd_ff <= 8'h00;
      evalid_ff <= 1'b0;
      eclass_ff <= 4'h0;
      ill_ff <= 1'b0;
      ret_ff <= 1'b0;
      cfg_meta_ff <= 1'b0;
      cfg_sync_ff <= 1'b0;
    end else begin
      ph_ff <= nxt_ph;
      ir_ff <= nxt_ir;
      is_xor_ff <= nxt_is_xor;
      res_ff <= nxt_res;
      wreg_ff <= nxt_wreg;
      bank_selection_register_ff <= nxt_bank;
      third_file_pointer_ff <= nxt_ptr2;
      neg_ff <= nxt_neg;
      zero_ff <= nxt_zero;
      xen_ff <= nxt_xen;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      wd_ff <= nxt_wd;
      evalid_ff <= nxt_evalid;
      eclass_ff <= nxt_eclass;
      ill_ff <= nxt_ill;
      ret_ff <= nxt_ret;
      cfg_meta_ff <= nxt_cfg_meta;
      cfg_sync_ff <= nxt_cfg_sync;
    end
  end

  // Extension needs both the synchronised strap and the control bit
  assign ext_on = xen_ff && cfg_sync_ff;
  // Outputs straight from flip-flops
  assign mem_addr = addr_ff;
  assign mem_rd = rd_ff;
  assign mem_wr = wr_ff;
  assign mem_wdata = wd_ff;
  assign ext_valid = evalid_ff;
  assign ext_class = eclass_ff;
  assign illegal_op = ill_ff;
  assign return_req = ret_ff;
endmodule : xfd_decode
`default_nettype wire

// File: sim/xfd_decode_asserts.sv
// Checker: port-level properties of the exclusive-OR decode slice
`timescale 1ns/1ps
`default_nettype none
module xfd_decode_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch and memory side
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  // Extended group side
  input wire logic ext_valid,
  input wire logic [3:0] ext_class,
  input wire logic illegal_op,
  input wire logic return_req
);
  import xfd_pkg::*;
  logic [1:0] ph_ff;
  logic [1:0] nxt_ph;
  logic take;
  logic take_xor;
  // Phase tracker, zero is Q1; free running so no fetch handshake is needed
  always_comb nxt_ph = rst_n ? ph_ff + 2'h1 : 2'h0;
  always_ff @(posedge clk) ph_ff <= nxt_ph;
  assign take = rst_n && instr_valid && (ph_ff == 2'h0);
  assign take_xor = take && (instr_word[15:10] == XFD_OP_XOR_FILE);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take_xor;
    take_xor;
  endsequence
  sequence s_file_read;
    ##2 mem_rd;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  chk_xor_read: assert property (s_take_xor |-> s_file_read)
    else $error("file read strobe missing");
  chk_read_cause: assert property (mem_rd |-> $past(take_xor, 2))
    else $error("file read without XOR");
  chk_dest_file: assert property (s_take_xor ##0 instr_word[9] |-> ##4 mem_wr)
    else $error("file write missing");
  chk_dest_w: assert property (s_take_xor ##0 !instr_word[9] |-> ##1 (!mem_wr) [*4])
    else $error("file written for W destination");
  chk_write_addr: assert property (mem_wr |-> mem_addr == $past(mem_addr, 2))
    else $error("write address moved");
  chk_access_high: assert property (s_take_xor ##0 (!instr_word[8] && instr_word[7]) |->
    ##2 mem_addr == {XFD_ACCESS_HIGH_BANK, $past(instr_word[7:0], 2)})
    else $error("access bank address wrong");
  chk_bank_low: assert property (s_take_xor ##0 instr_word[8] |->
    ##2 mem_addr[7:0] == $past(instr_word[7:0], 2))
    else $error("banked address offset wrong");
  chk_illegal_cause: assert property (illegal_op |->
    $past(take) && $past(instr_word[15:12]) == 4'he && !ext_valid)
    else $error("illegal flag without extended word");
  chk_ext_class: assert property (ext_valid |->
    $past(take) && ext_class >= 4'h2 && ext_class <= 4'h9)
    else $error("extended class out of range");
  chk_ret_class: assert property (return_req |->
    ext_valid && (ext_class == 4'h4 || ext_class == 4'h5))
    else $error("return without pointer-and-return class");
  chk_ret_cause: assert property (ext_valid && $past(instr_word[15:6]) == 10'h3a3 |->
    return_req && ext_class == 4'h4)
    else $error("add-and-return not flagged");
endmodule : xfd_decode_asserts
`default_nettype wire

// File: sim/xfd_mem_model.sv
// Partner: combinational data memory banks
`timescale 1ns/1ps
`default_nettype none
module xfd_mem_model (
  // Clock
  input wire logic clk,
  // Data memory side
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_q = 8'h5a;
  // Data valid only in the read cycle; otherwise inverted last value, not a held copy
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
  // Write port and last-read tracking
  always @(posedge clk) begin
    if (mem_rd) last_q <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule : xfd_mem_model
`default_nettype wire

// File: sim/xfd_decode_tb_top.sv
// Testbench: XOR decode, addressing modes and extended classification
`timescale 1ns/1ps
`default_nettype none
module xfd_decode_tb_top;
  import xfd_pkg::*;
  logic clk, rst_n, instr_valid, mem_rd, mem_wr, ext_valid, illegal_op, return_req, cfg_bit;
  logic [15:0] instr_word;
  logic [11:0] mem_addr, ra, wa;
  logic [7:0] mem_wdata, mem_rdata, wd, s_axi_awaddr, s_axi_araddr;
  logic [3:0] ext_class, gcls, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, got_rd, got_wr, gx, gill, gret;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, rv2, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, ph, r;
  int mismatches, checks, seed;
  logic [15:0] ew [8] = '{16'he805, 16'he8c5, 16'he905, 16'he9c5, 16'h0014, 16'heb05,
    16'heb85, 16'hea12};
  logic [3:0] ec [8] = '{4'h2, 4'h4, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  xfd_decode i_xfd_decode (.clk, .rst_n, .instr_word, .instr_valid,
    .extension_enable_config_bit(cfg_bit), .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
    .ext_valid, .ext_class, .illegal_op, .return_req, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  xfd_mem_model i_xfd_mem_model (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  // Clock and phase tracker; the tracker holds the phase of the edge just passed
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) ph <= rst_n ? ph + 2'h1 : 2'h0;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Write and read start one edge late so no strobe is assigned twice in a step
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin do @(posedge clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    while (!s_axi_bvalid) @(posedge clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // Issue one word at Q1, offer noise in Q2 (must be ignored), capture four cycles
  task automatic run_op(input logic [15:0] w);
    do @(posedge clk); while (ph != 2'h3);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_word <= 16'($random(seed));
    {got_rd, got_wr, gx, gill, gret} = '0;
    repeat (4) begin
      @(posedge clk);
      instr_valid <= 1'b0;
      if (mem_rd) {got_rd, ra} = {1'b1, mem_addr};
      if (mem_wr) {got_wr, wa, wd} = {1'b1, mem_addr, mem_wdata};
      if (ext_valid) {gx, gcls} = {1'b1, ext_class};
      gill |= illegal_op;
      gret |= return_req;
    end
  endtask : run_op
  function automatic logic [11:0] exp_addr(logic e, logic a, logic [7:0] f, logic [3:0] b,
    logic [11:0] p);
    if (a) return {b, f};
    if (e && f <= XFD_IDX_LIMIT) return p + {4'h0, f};
    return {f[7] ? XFD_ACCESS_HIGH_BANK : XFD_ACCESS_LOW_BANK, f};
  endfunction : exp_addr
  // Full exclusive-OR case: program state, preload file, run, compare
  task automatic xor_case(logic e, logic a, logic d, logic [7:0] f, logic [7:0] wv,
    logic [3:0] b, logic [11:0] p, logic [7:0] mv);
    logic [11:0] ea;
    logic [7:0] res;
    axw(XFD_ADDR_CTRL, {31'h0, e}, r);
    axw(XFD_ADDR_BANK, {28'h0, b}, r);
    axw(XFD_ADDR_WREG, {24'h0, wv}, r);
    axw(XFD_ADDR_PTR2, {20'h0, p}, r);
    ea = exp_addr(e, a, f, b, p);
    res = wv ^ mv;
    i_xfd_mem_model.mem[ea] = mv;
    run_op({XFD_OP_XOR_FILE, d, a, f});
    chk("read_addr", {got_rd, ra}, {1'b1, ea});
    chk("write_seen", got_wr, d);
    if (d) chk("write_addr_data", {wa, wd}, {ea, res});
    axr(XFD_ADDR_WREG, rd, r);
    chk("wreg", rd, {24'h0, d ? wv : res});
    axr(XFD_ADDR_STATUS, rd, r);
    chk("status", rd, {30'h0, res[7], res == 8'h0});
  endtask : xor_case
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'hf6cc4474;
    {rst_n, instr_valid, instr_word, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    cfg_bit = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axr(8'(4 * i), rd, r);
      chk("reset_resp", r, XFD_RESP_OKAY);
      chk("reset_value", rd, 32'h0);
    end
    axr(8'h18, rd, r);
    chk("unmapped_read_resp", r, XFD_RESP_SLVERR);
    chk("unmapped_read", rd, 32'h0);
    axw(8'h20, 32'h1, r);
    chk("unmapped_write", r, XFD_RESP_SLVERR);
    xor_case(1'b1, 1'b0, 1'b1, 8'h5f, 8'hb5, 4'h3, 12'hfc0, 8'hb5);
    xor_case(1'b1, 1'b0, 1'b0, 8'h60, 8'h0f, 4'h3, 12'h100, 8'hf0);
    xor_case(1'b0, 1'b0, 1'b1, 8'h10, 8'h01, 4'h3, 12'h100, 8'h03);
    xor_case(1'b1, 1'b0, 1'b1, 8'h85, 8'h55, 4'h2, 12'h200, 8'haa);
    xor_case(1'b0, 1'b1, 1'b1, 8'h5a, 8'hb5, 4'h7, 12'h000, 8'haf);
    // Pass 0 strap on with control off, pass 1 strap and control on, pass 2 control on with strap low
    for (int e = 0; e < 3; e++) begin
      cfg_bit <= (e != 2);
      axw(XFD_ADDR_CTRL, 32'(e != 0), r);
      for (int i = 0; i < 8; i++) begin
        run_op(ew[i]);
        chk("ext_valid", gx, e == 1);
        chk("illegal", gill, e != 1 && ew[i][15:12] == 4'he);
        chk("return", gret, e == 1 && (ec[i] == 4'h4 || ec[i] == 4'h5));
        if (e == 1) chk("class", gcls, ec[i]);
      end
    end
    cfg_bit <= 1'b1;
    repeat (24) begin
      rv = $random(seed);
      rv2 = $random(seed);
      xor_case(rv[0], rv[1], rv[2], rv[15:8], rv[23:16], rv[27:24], rv2[11:0], rv2[19:12]);
    end
    complete_run();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : xfd_decode_tb_top
bind xfd_decode xfd_decode_asserts i_xfd_decode_asserts (.clk, .rst_n, .instr_word,
  .instr_valid, .mem_addr, .mem_rd, .mem_wr, .ext_valid, .ext_class, .illegal_op, .return_req);
`default_nettype wire
